// File: ssd_core_model.sv
// far-side model of the core drain that takes buffered writes
`timescale 1ns/1ps
module ssd_core_model (
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst_n,
    input  wire logic [1:0] i_mode,
    output logic            o_ready
);
    logic tog_q;
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tog_q <= 1'b0;
        end else begin
            tog_q <= ~tog_q;
        end
    end
    // mode 0 prompt, 1 every other cycle, 2 stalled
    assign o_ready = i_rst_n && (i_mode == 2'h0 || (i_mode == 2'h1 && tog_q));
endmodule : ssd_core_model

// File: ssd_fifo.sv
// small flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ps
module ssd_fifo #(
    parameter int unsigned W     = 8,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic i_sys_clk,
    input  wire logic i_rst_n,
    ssd_fifo_if.dst   s_in,
    ssd_fifo_if.src   s_out
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [W-1:0]  mem_q [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0]   cnt_q, cnt_d;
    logic          push, pop;

    assign s_in.ready  = (cnt_q != (AW+1)'(DEPTH));
    assign s_out.valid = (cnt_q != '0);
    assign s_out.data  = mem_q[rd_q];
    assign push        = s_in.valid & s_in.ready;
    assign pop         = s_out.valid & s_out.ready;

    always_comb begin
        wr_d  = push ? ((wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1) : wr_q;
        rd_d  = pop ? ((rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1) : rd_q;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    // storage has no reset; contents are qualified by the count
    always_ff @(posedge i_sys_clk) begin
        if (push) begin
            mem_q[wr_q] <= s_in.data;
        end
    end
endmodule : ssd_fifo

// File: ssd_fifo_if.sv
// valid/ready carrier between the port and its write buffer
`timescale 1ns/1ps
interface ssd_fifo_if #(parameter int unsigned W = 8);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport dst (input valid, input data, output ready);
endinterface : ssd_fifo_if

// File: ssd_pkg.sv
// package of constants for the synchronous sram data port
package ssd_pkg;
    localparam int unsigned BYTE_W      = 8;
    localparam int unsigned BYTES_WIDE  = 4;
    localparam int unsigned ADDR_W      = 10;
    localparam int unsigned BURST_W     = 2;
    localparam int unsigned FIFO_DEPTH  = 8;
    localparam logic [1:0]  BURST_LAST  = 2'h3;
    localparam logic        ORDER_LIN   = 1'b0;
    localparam logic        ORDER_INTLV = 1'b1;
    typedef enum logic [1:0] {
        SSD_IDLE,
        SSD_READ,
        SSD_WRITE
    } ssd_cyc_t;
endpackage : ssd_pkg

// File: ssd_port.sv
// data port, output pipeline and burst address order of the sync sram
`timescale 1ns/1ps
// Contract
// R1: capture data and parity lines every rising edge
// R2: read data one cycle after address
// R3: drive lines only while output enable low; drive here stops two clocks after oe is sampled high, through the synchroniser
// R4: strap low linear, high interleaved order
// R5: host keeps burst-order strap static
// R6: interleaved address is start xor count
// R7: write cycle forces data lines off
// R8: first read after deselect stays off
// R9: deselect releases outputs one cycle later
// R10: data width is a build parameter
module ssd_port #(
    parameter int unsigned BYTES  = ssd_pkg::BYTES_WIDE,
    parameter int unsigned ADDR_W = ssd_pkg::ADDR_W,
    parameter int unsigned DEPTH  = ssd_pkg::FIFO_DEPTH
) (
    // clock and reset
    input  wire logic                    i_sys_clk,
    input  wire logic                    i_rst_n,
    // access controls, already qualified by strobes and selects
    input  wire logic                    i_sel_n,
    input  wire logic                    i_load,
    input  wire logic                    i_adv_n,
    input  wire logic                    i_wr_n,
    input  wire logic [ADDR_W-1:0]       i_addr,
    input  wire logic                    i_oe_n,
    input  wire logic                    i_order_strap,
    // data and parity lines
    input  wire logic [BYTES*8-1:0]      i_dq,
    input  wire logic [BYTES-1:0]        i_parity_io_lines,
    output logic      [BYTES*8-1:0]      o_dq,
    output logic      [BYTES-1:0]        o_parity_io_lines,
    output logic                         o_dq_oe,
    // write stream toward the memory core
    output logic                         o_wr_valid,
    output logic      [ADDR_W-1:0]       o_wr_addr,
    output logic      [BYTES*9-1:0]      o_wr_data,
    input  wire logic                    i_wr_ready,
    output logic                         o_busy
);
    localparam int unsigned DW  = BYTES * ssd_pkg::BYTE_W;          // R10
    localparam int unsigned PW  = BYTES * (ssd_pkg::BYTE_W + 1);
    localparam int unsigned FW  = ADDR_W + PW;
    localparam int unsigned WDS = 1 << ADDR_W;

    // pin synchronisers; oe is asynchronous at the pins
    logic [1:0] oe_s_q, oe_s_d, strap_s_q, strap_s_d;
    logic [DW-1:0] dq_s1_q, dq_s2_q;
    logic [BYTES-1:0] par_s1_q, par_s2_q;
    logic order_q, order_d;

    // control pipeline
    logic [ADDR_W-1:0] base_q, base_d;
    logic [1:0]        cnt_q, cnt_d;
    ssd_pkg::ssd_cyc_t cyc_q, cyc_d;
    logic              sel_q, sel_d;
    logic              desel_hold_q, desel_hold_d;
    logic              first_q, first_d;
    logic [ADDR_W-1:0] cur_addr;
    logic [1:0]        low_bits;

    // outputs
    logic [DW-1:0]     dq_q, dq_d;
    logic [BYTES-1:0]  par_q, par_d;
    logic              oe_q, oe_d;
    logic              busy_q, busy_d;

    // core storage, flip-flops by index
    logic [PW-1:0]     mem_q [WDS];
    logic [PW-1:0]     cap_word;

    ssd_fifo_if #(.W(FW)) wr_in ();
    ssd_fifo_if #(.W(FW)) wr_out ();

    always_comb begin
        oe_s_d    = {oe_s_q[0], i_oe_n};
        strap_s_d = {strap_s_q[0], i_order_strap};
        order_d   = strap_s_q[1];            // R4
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            oe_s_q    <= 2'h3;
            strap_s_q <= 2'h3;
            order_q   <= ssd_pkg::ORDER_INTLV;
            dq_s1_q   <= '0;
            dq_s2_q   <= '0;
            par_s1_q  <= '0;
            par_s2_q  <= '0;
        end else begin
            oe_s_q    <= oe_s_d;
            strap_s_q <= strap_s_d;
            order_q   <= order_d;
            dq_s1_q   <= i_dq;               // R1
            dq_s2_q   <= dq_s1_q;
            par_s1_q  <= i_parity_io_lines;  // R1
            par_s2_q  <= par_s1_q;
        end
    end

    // burst address generation; strap assumed static while in use
    always_comb begin
        if (order_q == ssd_pkg::ORDER_INTLV) begin
            low_bits = base_q[1:0] ^ cnt_q;  // R6
        end else begin
            low_bits = base_q[1:0] + cnt_q;  // R4
        end
        cur_addr = {base_q[ADDR_W-1:2], low_bits};
    end

    always_comb begin
        base_d       = base_q;
        cnt_d        = cnt_q;
        cyc_d        = cyc_q;
        sel_d        = sel_q;
        first_d      = 1'b0;
        desel_hold_d = 1'b0;
        if (i_load) begin
            sel_d = ~i_sel_n;
            if (!i_sel_n) begin
                base_d  = i_addr;
                cnt_d   = 2'h0;
                cyc_d   = i_wr_n ? ssd_pkg::SSD_READ : ssd_pkg::SSD_WRITE;
                first_d = ~sel_q;            // R8
            end else begin
                cyc_d        = ssd_pkg::SSD_IDLE;
                desel_hold_d = sel_q;        // R9
            end
        end else if (sel_q) begin
            cyc_d = i_wr_n ? ssd_pkg::SSD_READ : ssd_pkg::SSD_WRITE;
            if (!i_adv_n) begin
                cnt_d = cnt_q + 2'h1;        // wraps past BURST_LAST
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            base_q       <= '0;
            cnt_q        <= 2'h0;
            cyc_q        <= ssd_pkg::SSD_IDLE;
            sel_q        <= 1'b0;
            first_q      <= 1'b0;
            desel_hold_q <= 1'b0;
        end else begin
            base_q       <= base_d;
            cnt_q        <= cnt_d;
            cyc_q        <= cyc_d;
            sel_q        <= sel_d;
            first_q      <= first_d;
            desel_hold_q <= desel_hold_d;
        end
    end

    // output register and direction
    always_comb begin
        dq_d   = dq_q;
        par_d  = par_q;
        busy_d = wr_out.valid;
        if (cyc_q == ssd_pkg::SSD_READ) begin
            for (int b = 0; b < BYTES; b++) begin
                dq_d[b*8 +: 8] = mem_q[cur_addr][b*9 +: 8];   // R2
                par_d[b]       = mem_q[cur_addr][b*9 + 8];
            end
        end
        // double-cycle deselect keeps drivers one more cycle
        oe_d = ~oe_s_q[1]                                    // R3
             & ((cyc_q == ssd_pkg::SSD_READ) | desel_hold_q) // R9
             & ~first_q                                      // R8
             & (cyc_q != ssd_pkg::SSD_WRITE);                // R7
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            dq_q   <= '0;
            par_q  <= '0;
            oe_q   <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            dq_q   <= dq_d;
            par_q  <= par_d;
            oe_q   <= oe_d;
            busy_q <= busy_d;
        end
    end

    // write capture: interleave parity with each byte
    always_comb begin
        for (int b = 0; b < BYTES; b++) begin
            cap_word[b*9 +: 9] = {par_s2_q[b], dq_s2_q[b*8 +: 8]};
        end
    end

    // a full buffer drops the word; busy warns the host to pace writes
    assign wr_in.valid = (cyc_q == ssd_pkg::SSD_WRITE);
    assign wr_in.data  = {cur_addr, cap_word};
    assign wr_out.ready = i_wr_ready;

    ssd_fifo #(.W(FW), .DEPTH(DEPTH)) u_wbuf (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (i_rst_n),
        .s_in      (wr_in),
        .s_out     (wr_out)
    );

    // core array written as words leave the buffer
    always_ff @(posedge i_sys_clk) begin
        if (wr_out.valid && i_wr_ready) begin
            mem_q[wr_out.data[FW-1:PW]] <= wr_out.data[PW-1:0];
        end
    end

    logic              wv_q;
    logic [FW-1:0]     wd_q;
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wv_q <= 1'b0;
            wd_q <= '0;
        end else begin
            wv_q <= wr_out.valid & i_wr_ready;
            wd_q <= wr_out.data;
        end
    end

    assign o_dq              = dq_q;
    assign o_parity_io_lines = par_q;
    assign o_dq_oe           = oe_q;
    assign o_busy            = busy_q;
    assign o_wr_valid        = wv_q;
    assign o_wr_addr         = wd_q[FW-1:PW];
    assign o_wr_data         = wd_q[PW-1:0];
endmodule : ssd_port

// File: ssd_port_sva.sv
// assertions on the ports of the sram data port
`timescale 1ns/1ps
module ssd_port_sva (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_sel_n,
    input wire logic i_load,
    input wire logic i_wr_n,
    input wire logic i_oe_n,
    input wire logic i_wr_ready,
    input wire logic o_dq_oe,
    input wire logic o_wr_valid,
    input wire logic o_busy
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_rd;    i_load && !i_sel_n && i_wr_n;  endsequence
    sequence s_wr;    i_load && !i_sel_n && !i_wr_n; endsequence
    sequence s_desel; i_load && i_sel_n;             endsequence
    sequence s_rd2;   (i_load && !i_sel_n && i_wr_n && !i_oe_n) [*2] ##1 !i_oe_n; endsequence
    a_oe_high_off: assert property (i_oe_n [*4] |=> !o_dq_oe) else $error("drive with oe high");
    a_write_no_drive: assert property (s_wr |-> ##2 !o_dq_oe) else $error("drive in write");
    a_first_rd_off: assert property (s_desel ##1 !i_load [*2] ##1 s_rd |-> ##2 !o_dq_oe)
        else $error("drive on first read");
    a_desel_release: assert property (s_desel ##1 !i_load |-> ##2 !o_dq_oe)
        else $error("drive after deselect");
    a_rd_drive_on: assert property (s_rd2 |=> o_dq_oe) else $error("read not driven");
    a_reset_quiet: assert property (disable iff (1'b0) !i_rst_n |-> !o_dq_oe && !o_busy)
        else $error("outputs active in reset");
    a_wr_buffered: assert property (s_wr |-> ##[1:3] (o_busy || o_wr_valid))
        else $error("write not buffered");
    a_valid_had_busy: assert property (o_wr_valid |-> o_busy) else $error("valid no backlog");
    a_stall_no_valid: assert property (!i_wr_ready [*2] |-> !o_wr_valid)
        else $error("valid while stalled");
endmodule : ssd_port_sva
bind ssd_port ssd_port_sva i_ssd_port_sva (.i_sys_clk, .i_rst_n, .i_sel_n, .i_load, .i_wr_n,
    .i_oe_n, .i_wr_ready, .o_dq_oe, .o_wr_valid, .o_busy);

// File: tb.sv
// self-checking bench for the sram data port
`timescale 1ns/1ps
module tb;
    typedef struct {logic [9:0] a; logic [31:0] d; logic [3:0] p;} ssd_row_t;
    ssd_row_t    rows [8];
    logic        i_sys_clk = 1'b0, i_rst_n = 1'b1, i_sel_n = 1'b1, i_load = 1'b0;
    logic        i_adv_n = 1'b1, i_wr_n = 1'b1, i_oe_n = 1'b1, i_order_strap = 1'b1;
    logic [9:0]  i_addr = 10'h000;
    logic [31:0] i_dq = 32'h0, o_dq;
    logic [3:0]  i_parity_io_lines = 4'h0, o_parity_io_lines;
    logic [1:0]  mode = 2'h2;
    logic        wr_ready, o_dq_oe, o_wr_valid, o_busy;
    logic [9:0]  o_wr_addr;
    logic [35:0] o_wr_data;
    logic [1:0]  s;
    int          fail_count = 0, n_compared = 0, extra;
    ssd_port i_ssd_port (.i_sys_clk, .i_rst_n, .i_sel_n, .i_load, .i_adv_n, .i_wr_n, .i_addr,
        .i_oe_n, .i_order_strap, .i_dq, .i_parity_io_lines, .o_dq, .o_parity_io_lines,
        .o_dq_oe, .o_wr_valid, .o_wr_addr, .o_wr_data, .i_wr_ready(wr_ready), .o_busy);
    ssd_core_model i_ssd_core_model (.i_sys_clk, .i_rst_n, .i_mode(mode), .o_ready(wr_ready));
    always #12.5 i_sys_clk = ~i_sys_clk;
    task automatic tick(input int n);
        repeat (n) @(posedge i_sys_clk);
        #2;
    endtask : tick
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic access(input logic [9:0] a, input logic wr, input logic sel_n);
        i_load = 1'b1;
        i_sel_n = sel_n;
        i_wr_n = ~wr;
        i_addr = a;
        tick(1);
    endtask : access
    task automatic idle(input int n);
        i_load = 1'b0;
        i_wr_n = 1'b1;
        tick(n);
    endtask : idle
    function automatic logic [35:0] wdat(input logic [31:0] d, input logic [3:0] p);
        for (int b = 0; b < 4; b++) wdat[9*b+:9] = {p[b], d[8*b+:8]};
    endfunction : wdat
    task automatic stop_test();
        $display("compares %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : stop_test
    // whole run is under 200 cycles; allow ten times that
    initial begin
        #50000;
        fail_count++;
        stop_test();
    end
    initial begin
        for (int r = 0; r < 8; r++) begin
            rows[r].a = (r < 4) ? 10'(64 + r) : 10'(1016 + r);
            rows[r].d = {8'(r * 37), 8'hc3, 8'(~r), 8'h5a};
            rows[r].p = 4'(r + 9);
        end
        // a real falling edge so the async flops clear before the first clock
        #1 i_rst_n = 1'b0;
        tick(8);
        i_rst_n = 1'b1;
        tick(3);
        // core stalled: eight writes fill the buffer, the ninth is dropped
        for (int r = 0; r < 9; r++) begin
            i_dq = rows[r % 8].d;
            i_parity_io_lines = rows[r % 8].p;
            tick(3);
            access(rows[r % 8].a, 1'b1, 1'b0);
            idle(2);
        end
        chk(o_busy, 36'h1);
        mode = 2'h1;
        for (int r = 0; r < 8; r++) begin
            for (int w = 0; w < 40 && o_wr_valid !== 1'b1; w++) tick(1);
            chk(o_wr_addr, rows[r].a);
            chk(o_wr_data, wdat(rows[r].d, rows[r].p));
            tick(1);
        end
        extra = 0;
        repeat (12) begin
            tick(1);
            extra += o_wr_valid;
        end
        chk(extra, 36'h0);
        mode = 2'h0;
        i_oe_n = 1'b0;
        i_dq = ~i_dq;
        for (int r = 0; r < 8; r++) begin
            access(rows[r].a, 1'b0, 1'b0);
            idle(2);
            chk({o_parity_io_lines, o_dq}, {rows[r].p, rows[r].d});
        end
        for (int m = 0; m < 2; m++) begin
            i_order_strap = (m == 0);
            access(10'h000, 1'b0, 1'b1);
            idle(6);
            access(rows[1].a, 1'b0, 1'b0);
            idle(2);
            for (int k = 1; k < 4; k++) begin
                i_adv_n = 1'b0;
                tick(1);
                i_adv_n = 1'b1;
                tick(2);
                s = (m == 0) ? (2'h1 ^ 2'(k)) : 2'(1 + k);
                chk(o_dq, rows[s].d);
                chk(o_dq_oe, 36'h1);
            end
        end
        access(rows[2].a, 1'b0, 1'b0);
        access(rows[3].a, 1'b0, 1'b0);
        idle(2);
        chk(o_dq, rows[3].d);
        access(10'h000, 1'b0, 1'b1);
        chk(o_dq_oe, 36'h1);
        idle(1);
        chk(o_dq_oe, 36'h1);
        idle(1);
        chk(o_dq_oe, 36'h0);
        access(rows[0].a, 1'b0, 1'b0);
        idle(1);
        chk(o_dq_oe, 36'h0);
        chk(o_dq, rows[0].d);
        idle(1);
        chk(o_dq, rows[0].d);
        chk(o_dq_oe, 36'h1);
        access(rows[4].a, 1'b1, 1'b0);
        idle(1);
        chk(o_dq_oe, 36'h0);
        idle(1);
        i_oe_n = 1'b1;
        idle(4);
        chk(o_dq_oe, 36'h0);
        i_rst_n = 1'b0;
        tick(2);
        chk({o_dq_oe, o_busy, o_wr_valid, o_dq}, 36'h0);
        i_rst_n = 1'b1;
        tick(3);
        stop_test();
    end
endmodule : tb
